// ===== rtl/twc_defs.svh
// Purpose: Register indexes, field positions and reset values of the two-wire controller
// Assumes: Included by the controller module and the testbench
// Notes: Byte address of a register is four times its index
`ifndef TWC_DEFS_SVH
`define TWC_DEFS_SVH

// Register indexes
`define TWC_IDX_SECOND_ADDR 8'hD6
`define TWC_IDX_OWN_ADDR 8'hD7
`define TWC_IDX_MODE 8'hDA
`define TWC_IDX_STATUS 8'hDB
`define TWC_IDX_LOW 8'hDC
`define TWC_IDX_HIGH 8'hDD
`define TWC_IDX_HOLD 8'hDE
`define TWC_IDX_DATA 8'hDF

// Reset values
`define TWC_RST_ADDR 8'h00
`define TWC_RST_MODE 8'h00
`define TWC_RST_STATUS 8'h00
`define TWC_RST_LOW 8'h3F
`define TWC_RST_HIGH 8'h3F
`define TWC_RST_HOLD 8'h01
`define TWC_RST_DATA 8'hFF

// Mode control field positions
`define TWC_MB_IRQ_FLAG 7
`define TWC_MB_ENABLE 6
`define TWC_MB_SOFT_RESET 5
`define TWC_MB_IRQ_ENABLE 4
`define TWC_MB_ACK_ENABLE 3
`define TWC_MB_STOP 1
`define TWC_MB_START 0

// Own address fields
`define TWC_AB_GC_ACCEPT 0

// Bit slot of the acknowledge within a byte
`define TWC_ACK_SLOT 4'h8
`define TWC_LAST_DATA_SLOT 4'h7

`endif

// ===== rtl/twc_pkg.sv
// Purpose: Types shared by the two-wire controller
// Assumes: Nothing beyond the defs header
// Notes: Status word order matches the readable status register
package twc_pkg;

   typedef enum logic [2:0] {
      M_IDLE = 3'h0,
      M_START = 3'h1,
      M_LOW = 3'h2,
      M_HIGH = 3'h3,
      M_STOP_LOW = 3'h4,
      M_STOP_HIGH = 3'h5,
      M_RS_LOW = 3'h6,
      M_RS_HIGH = 3'h7
   } mst_state_t;

   typedef struct packed {
      logic gc;
      logic done;
      logic stop;
      logic sel;
      logic lost;
      logic busy;
      logic tx;
      logic ack;
   } status_t;

endpackage

// ===== rtl/two_wire_bus_controller.sv
// Purpose: Two-wire serial bus controller, master or slave, behind an APB slave port
// Assumes: MCLK 40 MHz, RESETN synchronous active low, open-drain pins resolved outside
// Notes: Zero-wait APB, registers one aligned word each at four times their index
//
// Summary of operation
// - Controller logic runs only while the enable bit is one.
// - Writing one to soft reset reinitialises the engine; bit clears itself.
// - Interrupt output is raised only while interrupt enable is one.
// - In the ninth slot SDA is pulled low as acknowledge when acknowledge enable is one.
// - Read-only mode bit shows one while master, zero while slave.
// - Stop request while master produces a STOP condition.
// - Start request produces START, or repeated START mid-transfer.
// - Interrupt flag reads one once an interrupt event has occurred.
// - Status top bit: address acknowledged as master, general call as slave.
// - Byte-done bit sets after each full byte except the address byte received as slave, and interrupts.
// - Stop-detected bit sets on any STOP on the bus and interrupts.
// - Slave-selected bit sets when addressed by another master and interrupts.
// - Arbitration-lost bit sets when mastership is lost and interrupts.
// - Busy bit is one between START and STOP, zero when idle.
// - Direction bit is one while transmitter, zero while receiver.
// - Acknowledge bit shows an acknowledge in the ninth slot of the last byte.
// - Every interrupt but stop holds SCL low until status is written.
// - Any status write clears the event bits and releases SCL.
// - Master SCL low lasts four times low count plus one clocks.
// - Master SCL high lasts four times high count plus three clocks.
// - SDA changes hold count plus one clocks after each SCL falling edge.
// - Data register supplies transmitted bytes and captures received bytes.
// - Slave selects only on address match with acknowledge enable, else idles.
// - Received address compares with own and second address; general call only if accepted.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "twc_defs.svh"

module two_wire_bus_controller
   import twc_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // System
   input wire logic MCLK,
   input wire logic RESETN,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Two-wire pins, open drain
   input wire logic SCL_SENSE,
   output logic SCL_LEVEL,
   output logic SCL_PULL,
   input wire logic SDA_SENSE,
   output logic SDA_LEVEL,
   output logic SDA_PULL,
   // Interrupt
   output logic IRQ
);

   if (ADDR_W < 11) begin : g_check
      $error("ADDR_W must be at least 11 to reach the register window");
   end

   function automatic logic [9:0] phase_len(input logic [7:0] v, input logic [1:0] extra);
      return {v, 2'b00} + {8'h00, extra};
   endfunction

   function automatic logic [1:0] addr_hit(input logic [6:0] a, input logic [7:0] r);
      logic gc;
      gc = (a == 7'h00) && r[`TWC_AB_GC_ACCEPT];
      return {gc, ((a != 7'h00) && (a == r[7:1])) || gc};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////
   // APB decode
   logic [7:0] idx;
   logic addr_ok, wr_en, wr_mode, stat_wr;
   assign idx = PADDR[9:2];
   assign addr_ok = (PADDR[1:0] == 2'h0) && (PADDR[ADDR_W-1:10] == '0) &&
                    (idx inside {`TWC_IDX_SECOND_ADDR, `TWC_IDX_OWN_ADDR, `TWC_IDX_MODE,
                                 `TWC_IDX_STATUS, `TWC_IDX_LOW, `TWC_IDX_HIGH,
                                 `TWC_IDX_HOLD, `TWC_IDX_DATA});
   assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
   assign wr_mode = wr_en && (idx == `TWC_IDX_MODE);
   assign stat_wr = wr_en && (idx == `TWC_IDX_STATUS);
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !addr_ok;

   // Configuration
   logic [7:0] sar_q, sar1_q, low_q, high_q, hold_count_q;
   logic enable_q, irq_en_q, ack_en_q, soft_rst_q, erst, srst;
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         sar_q <= `TWC_RST_ADDR;
         sar1_q <= `TWC_RST_ADDR;
         low_q <= `TWC_RST_LOW;
         high_q <= `TWC_RST_HIGH;
         hold_count_q <= `TWC_RST_HOLD;
         enable_q <= 1'b0;
         irq_en_q <= 1'b0;
         ack_en_q <= 1'b0;
      end else if (wr_en) begin
         unique case (idx)
            `TWC_IDX_OWN_ADDR: sar_q <= PWDATA[7:0];
            `TWC_IDX_SECOND_ADDR: sar1_q <= PWDATA[7:0];
            `TWC_IDX_LOW: low_q <= PWDATA[7:0];
            `TWC_IDX_HIGH: high_q <= PWDATA[7:0];
            `TWC_IDX_HOLD: hold_count_q <= PWDATA[7:0];
            `TWC_IDX_MODE: begin
               enable_q <= PWDATA[`TWC_MB_ENABLE];
               irq_en_q <= PWDATA[`TWC_MB_IRQ_ENABLE];
               ack_en_q <= PWDATA[`TWC_MB_ACK_ENABLE];
            end
            default: ;
         endcase
      end
   end

   // Pulse lasts one clock; the mode read returns this bit as a constant zero
   always_ff @(posedge MCLK) begin
      if (!RESETN) soft_rst_q <= 1'b0;
      else soft_rst_q <= wr_mode && PWDATA[`TWC_MB_SOFT_RESET];
   end
   assign srst = !RESETN || soft_rst_q;
   assign erst = srst || !enable_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Pin sampling: three stages, level accepted when the last two agree
   logic [2:0] scl_s_q, sda_s_q;
   logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], SCL_SENSE};
         sda_s_q <= {sda_s_q[1:0], SDA_SENSE};
         if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
         if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
         scl_p_q <= scl_f_q;
         sda_p_q <= sda_f_q;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_f_q && !scl_p_q;
   assign scl_fall = !scl_f_q && scl_p_q;
   assign start_det = enable_q && scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
   assign stop_det = enable_q && scl_f_q && scl_p_q && !sda_p_q && sda_f_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Byte engine
   logic engaged_q, addr_ph_q, master_q, tx_q;
   logic [3:0] bitcnt_q;
   logic [7:0] data_q;
   logic [1:0] hit0, hit1;
   logic match, gc_hit, fall_byte, fall_ack, slave_take, slave_drop;
   logic ev_done, ev_sel, ev_lost, ev_stop, ev_hold, ev_any, ack_set;
   assign hit0 = addr_hit(data_q[7:1], sar_q);
   assign hit1 = addr_hit(data_q[7:1], sar1_q);
   assign match = hit0[0] || hit1[0];
   assign gc_hit = hit0[1] || hit1[1];
   assign fall_byte = scl_fall && engaged_q && (bitcnt_q == `TWC_LAST_DATA_SLOT);
   assign fall_ack = scl_fall && engaged_q && (bitcnt_q == `TWC_ACK_SLOT);
   assign slave_take = fall_byte && addr_ph_q && !master_q && match && ack_en_q;
   assign slave_drop = fall_byte && addr_ph_q && !master_q && !(match && ack_en_q);
   assign ev_sel = !erst && fall_ack && addr_ph_q && !master_q;
   assign ev_done = !erst && fall_ack && !(addr_ph_q && !master_q);
   assign ev_lost = !erst && scl_rise && engaged_q && master_q && tx_q &&
                    (bitcnt_q < `TWC_ACK_SLOT) && data_q[7] && !sda_f_q;
   assign ev_stop = !erst && stop_det;
   assign ev_hold = ev_done || ev_sel || ev_lost;
   assign ev_any = ev_hold || ev_stop;
   assign ack_set = scl_rise && engaged_q && (bitcnt_q == `TWC_ACK_SLOT);

   always_ff @(posedge MCLK) begin
      if (erst) begin
         engaged_q <= 1'b0;
         addr_ph_q <= 1'b0;
         bitcnt_q <= 4'h0;
      end else if (stop_det) begin
         engaged_q <= 1'b0;
         addr_ph_q <= 1'b0;
         bitcnt_q <= 4'h0;
      end else if (start_det) begin
         engaged_q <= 1'b1;
         addr_ph_q <= 1'b1;
         // The SCL fall that closes the START wraps this to slot zero
         bitcnt_q <= 4'hF;
      end else if (ev_lost) begin
         engaged_q <= 1'b0;
      end else if (scl_fall && engaged_q) begin
         if (slave_drop) engaged_q <= 1'b0;
         if (bitcnt_q == `TWC_ACK_SLOT) begin
            bitcnt_q <= 4'h0;
            addr_ph_q <= 1'b0;
         end else begin
            bitcnt_q <= bitcnt_q + 4'h1;
         end
      end
   end

   // Data register doubles as the shift register
   always_ff @(posedge MCLK) begin
      if (srst) data_q <= `TWC_RST_DATA;
      else if (scl_rise && engaged_q && (bitcnt_q < `TWC_ACK_SLOT))
         data_q <= {data_q[6:0], sda_f_q};
      else if (wr_en && (idx == `TWC_IDX_DATA)) data_q <= PWDATA[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Status and interrupt flag; an event always beats a clearing write
   logic gc_q, done_q, stopd_q, sel_q, lost_q, busy_q, ack_q, irq_flag_q, scl_hold_q;
   always_ff @(posedge MCLK) begin
      if (erst) begin
         gc_q <= 1'b0;
         done_q <= 1'b0;
         stopd_q <= 1'b0;
         sel_q <= 1'b0;
         lost_q <= 1'b0;
         busy_q <= 1'b0;
         tx_q <= 1'b0;
         ack_q <= 1'b0;
         scl_hold_q <= 1'b0;
      end else begin
         done_q <= ev_done || (done_q && !stat_wr);
         stopd_q <= ev_stop || (stopd_q && !stat_wr);
         sel_q <= ev_sel || (sel_q && !stat_wr);
         lost_q <= ev_lost || (lost_q && !stat_wr);
         scl_hold_q <= ev_hold || (scl_hold_q && !stat_wr);
         if (ack_set) ack_q <= !sda_f_q;
         else if (stat_wr) ack_q <= 1'b0;
         if (start_det) busy_q <= 1'b1;
         else if (stop_det) busy_q <= 1'b0;
         if (start_det) gc_q <= 1'b0;
         else if (slave_take) gc_q <= gc_hit;
         else if (fall_ack && addr_ph_q && master_q) gc_q <= ack_q;
         if (start_det) tx_q <= master_q;
         else if (fall_ack && addr_ph_q) tx_q <= master_q ? !data_q[0] : data_q[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Master clock generator
   mst_state_t mst_q;
   logic [9:0] cnt_q, lo_len, hi_len;
   logic cnt_done, boundary, go_start, stop_done, start_req_q, stop_req_q;
   assign lo_len = phase_len(low_q, 2'h0);
   assign hi_len = phase_len(high_q, 2'h2);
   assign cnt_done = (cnt_q == 10'h000);
   assign boundary = (bitcnt_q == 4'h0) && !addr_ph_q;
   assign go_start = !erst && !ev_lost &&
                     ((mst_q == M_IDLE && start_req_q && !busy_q) ||
                      (mst_q == M_RS_HIGH && cnt_done));
   assign stop_done = !erst && !ev_lost && (mst_q == M_STOP_HIGH) && cnt_done;

   always_ff @(posedge MCLK) begin
      if (erst || ev_lost) begin
         mst_q <= M_IDLE;
         cnt_q <= 10'h000;
         master_q <= 1'b0;
      end else begin
         if (!cnt_done && !(mst_q == M_LOW && scl_hold_q)) cnt_q <= cnt_q - 10'h001;
         unique case (mst_q)
            M_IDLE: if (go_start) begin
               mst_q <= M_START;
               cnt_q <= hi_len;
               master_q <= 1'b1;
            end
            M_START: if (cnt_done) begin
               mst_q <= M_LOW;
               cnt_q <= lo_len;
            end
            M_LOW: if (cnt_done && !scl_hold_q) begin
               cnt_q <= (boundary && (stop_req_q || start_req_q)) ? lo_len : hi_len;
               if (boundary && stop_req_q) mst_q <= M_STOP_LOW;
               else if (boundary && start_req_q) mst_q <= M_RS_LOW;
               else mst_q <= M_HIGH;
            end
            M_HIGH: if (cnt_done) begin
               mst_q <= M_LOW;
               cnt_q <= lo_len;
            end
            M_STOP_LOW: if (cnt_done) begin
               mst_q <= M_STOP_HIGH;
               cnt_q <= hi_len;
            end
            M_STOP_HIGH: if (cnt_done) begin
               mst_q <= M_IDLE;
               master_q <= 1'b0;
            end
            M_RS_LOW: if (cnt_done) begin
               mst_q <= M_RS_HIGH;
               cnt_q <= hi_len;
            end
            M_RS_HIGH: if (cnt_done) begin
               mst_q <= M_START;
               cnt_q <= hi_len;
            end
         endcase
      end
   end

   // Requests and flag; a one written sets a request (stop only while master), a zero written clears the flag
   always_ff @(posedge MCLK) begin
      if (erst) begin
         start_req_q <= 1'b0;
         stop_req_q <= 1'b0;
         irq_flag_q <= 1'b0;
      end else begin
         if (wr_mode && PWDATA[`TWC_MB_START]) start_req_q <= 1'b1;
         else if (go_start) start_req_q <= 1'b0;
         if (wr_mode && PWDATA[`TWC_MB_STOP] && master_q) stop_req_q <= 1'b1;
         else if (stop_done) stop_req_q <= 1'b0;
         if (ev_any) irq_flag_q <= 1'b1;
         else if (stat_wr || (wr_mode && !PWDATA[`TWC_MB_IRQ_FLAG])) irq_flag_q <= 1'b0;
      end
   end
   assign IRQ = irq_flag_q && irq_en_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // SDA launch timer; a release of SCL re-arms it so freshly loaded data goes out
   logic [7:0] tmr_q;
   logic tmr_run_q, sda_bit_q, sda_val;
   always_comb begin
      sda_val = 1'b0;
      if (engaged_q && bitcnt_q < `TWC_ACK_SLOT) sda_val = tx_q && !data_q[7];
      else if (engaged_q)
         sda_val = ack_en_q && ((addr_ph_q && !master_q) || (!addr_ph_q && !tx_q));
   end

   always_ff @(posedge MCLK) begin
      if (erst || start_det || stop_det || mst_q == M_STOP_LOW || mst_q == M_RS_LOW) begin
         tmr_q <= 8'h00;
         tmr_run_q <= 1'b0;
         sda_bit_q <= 1'b0;
      end else if ((scl_fall && engaged_q) || (stat_wr && scl_hold_q)) begin
         tmr_q <= hold_count_q;
         tmr_run_q <= 1'b1;
      end else if (tmr_run_q) begin
         if (tmr_q == 8'h00) begin
            tmr_run_q <= 1'b0;
            sda_bit_q <= sda_val;
         end else begin
            tmr_q <= tmr_q - 8'h01;
         end
      end
   end

   // Pins: level always low, the enables decide
   assign SCL_LEVEL = 1'b0;
   assign SDA_LEVEL = 1'b0;
   assign SCL_PULL = scl_hold_q || mst_q inside {M_LOW, M_STOP_LOW, M_RS_LOW};
   assign SDA_PULL = (mst_q inside {M_START, M_STOP_LOW, M_STOP_HIGH}) ||
                     (!(mst_q inside {M_RS_LOW, M_RS_HIGH}) && sda_bit_q);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Read data registered in the setup phase
   status_t st;
   logic [7:0] rd;
   assign st = {gc_q, done_q, stopd_q, sel_q, lost_q, busy_q, tx_q, ack_q};
   always_comb begin
      unique case (idx)
         `TWC_IDX_OWN_ADDR: rd = sar_q;
         `TWC_IDX_SECOND_ADDR: rd = sar1_q;
         `TWC_IDX_MODE: rd = {irq_flag_q, enable_q, 1'b0, irq_en_q, ack_en_q, master_q,
                              stop_req_q, start_req_q};
         `TWC_IDX_STATUS: rd = st;
         `TWC_IDX_LOW: rd = low_q;
         `TWC_IDX_HIGH: rd = high_q;
         `TWC_IDX_HOLD: rd = hold_count_q;
         `TWC_IDX_DATA: rd = data_q;
         default: rd = 8'h00;
      endcase
   end
   always_ff @(posedge MCLK) begin
      if (!RESETN) PRDATA <= 32'h0000_0000;
      else if (PSEL && !PENABLE) PRDATA <= {24'h00_0000, addr_ok ? rd : 8'h00};
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [9:0] seen_low_q, seen_high_q;
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         seen_low_q <= 10'h000;
         seen_high_q <= 10'h000;
      end else begin
         seen_low_q <= (mst_q != M_LOW) ? 10'h000 : seen_low_q + {9'h000, !scl_hold_q};
         seen_high_q <= (mst_q != M_HIGH) ? 10'h000 : seen_high_q + 10'h001;
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   sequence s_event;
      ev_any;
   endsequence
   sequence s_hold_wait;
      ev_hold ##1 (!stat_wr && !erst) [*4];
   endsequence

   a_soft_reset_pulse: assert property (
      wr_mode && PWDATA[`TWC_MB_SOFT_RESET] |=> soft_rst_q ##1 !soft_rst_q)
      else $error("soft reset did not self-clear");
   a_disabled_quiet: assert property (
      !enable_q |=> !SCL_PULL && !SDA_PULL && mst_q == M_IDLE && !busy_q)
      else $error("controller active while disabled");
   a_irq_raised: assert property (
      s_event ##1 (irq_en_q && !erst && !stat_wr) |-> IRQ)
      else $error("enabled interrupt not raised");
   a_flag_sets: assert property (
      s_event |=> irq_flag_q)
      else $error("interrupt flag not set by event");
   a_master_mode: assert property (
      mst_q != M_IDLE |-> master_q)
      else $error("mode bit not master while generating clock");
   a_start_request: assert property (
      mst_q == M_IDLE && start_req_q && !busy_q && !erst && !ev_lost
      |=> mst_q == M_START && SDA_PULL && !start_req_q)
      else $error("start request not served");
   a_stop_request: assert property (
      stop_done |=> mst_q == M_IDLE && !SDA_PULL && !master_q && !stop_req_q)
      else $error("stop not completed");
   a_status_clear: assert property (
      stat_wr && !ev_any && !ack_set && !erst
      |=> !done_q && !stopd_q && !sel_q && !lost_q && !ack_q && !scl_hold_q)
      else $error("status write did not clear");
   a_scl_held: assert property (
      s_hold_wait |-> SCL_PULL)
      else $error("SCL released before status write");
   a_low_period: assert property (
      mst_q == M_LOW && cnt_done && !scl_hold_q && !erst && !ev_lost |-> seen_low_q == lo_len)
      else $error("SCL low period wrong");
   a_high_period: assert property (
      mst_q == M_HIGH && cnt_done && !erst && !ev_lost |-> seen_high_q == hi_len)
      else $error("SCL high period wrong");
   a_ack_drive: assert property (
      tmr_run_q && tmr_q == 8'h00 && engaged_q && bitcnt_q == `TWC_ACK_SLOT && ack_en_q &&
      !tx_q && !addr_ph_q && !master_q && !erst && !start_det && !stop_det |=> SDA_PULL)
      else $error("acknowledge not driven");
   a_addr_drop: assert property (
      slave_drop && !erst |=> !engaged_q)
      else $error("unmatched slave still engaged");

endmodule // two_wire_bus_controller

// ===== tb/twc_bus_peer.sv
// Purpose: Far-side bus slave that acknowledges one fixed address byte
// Assumes: Wires resolved by the bench, released lines read high
// Notes: Behavioural, follows the wire edges only
`timescale 1ns/1ps
module twc_bus_peer #(
   parameter logic [6:0] ADDR = 7'h2A
) (
   // Bus wires
   input wire logic scl,
   input wire logic sda,
   // Open-drain drive
   output logic sda_pull
);
   int bits = 0;
   logic [7:0] shift_q = 8'h00;
   initial sda_pull = 1'b0;
   ////////////////////////////////////////////////////////////////////////////////
   // A falling SDA while SCL is high restarts the byte count
   always @(negedge sda) begin
      if (scl === 1'b1)
         bits = 0;
   end
   always @(posedge scl) begin
      shift_q = {shift_q[6:0], sda};
      bits++;
   end
   // Pull from the eighth to the ninth SCL fall, so the master samples a settled ack
   always @(negedge scl) begin
      sda_pull <= (bits == 8 && shift_q[7:1] == ADDR);
   end
endmodule // twc_bus_peer

// ===== tb/tb_two_wire_bus_controller.sv
// Purpose: Self-checking bench for the two-wire controller over APB
// Assumes: Zero-wait APB, one acking peer on the bus
// Notes: Short SCL counts keep each byte near 200 clocks
`timescale 1ns/1ps
`include "twc_defs.svh"
module tb_two_wire_bus_controller;
   logic MCLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, prev, err;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic PREADY, PSLVERR, SCL_PULL, SDA_PULL, IRQ, peer_pull, scl, sda;
   logic [7:0] rd;
   logic [1:0] lvl;
   int n_mismatch = 0, checked = 0, lo_len, hi_len, run;
   logic [7:0] idx_t[8] = '{8'hD6, 8'hD7, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF};
   logic [7:0] rst_t[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h3F, 8'h01, 8'hFF};
   always #12.5 MCLK = ~MCLK;
   assign scl = ~SCL_PULL;
   assign sda = ~(SDA_PULL | peer_pull);
   two_wire_bus_controller #(.ADDR_W(12)) i_dut (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_SENSE(scl), .SCL_LEVEL(lvl[1]), .SCL_PULL(SCL_PULL),
      .SDA_SENSE(sda), .SDA_LEVEL(lvl[0]), .SDA_PULL(SDA_PULL), .IRQ(IRQ));
   twc_bus_peer #(.ADDR(7'h2A)) i_peer (.scl(scl), .sda(sda), .sda_pull(peer_pull));
   ////////////////////////////////////////////////////////////////////////////////
   // Run lengths of the SCL pull in clocks
   always @(posedge MCLK) begin
      if (SCL_PULL !== prev) begin
         if (prev === 1'b1) lo_len = run;
         else hi_len = run;
         run = 1;
      end else run++;
      prev = SCL_PULL;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, got, msk);
      checked++;
      if ((got & msk) !== (exp & msk)) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One transfer; released an edge later so back-to-back calls never collide
   task automatic apb(input logic w, input logic [7:0] idx, wd);
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= 12'({idx, 2'b00});
      PWDATA <= {24'h0, wd};
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge MCLK);
      end while (PREADY !== 1'b1);
      rd = PRDATA[7:0];
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, wd);
      apb(1'b1, idx, wd);
   endtask
   task automatic rc(input string nm, input logic [7:0] idx, exp, msk);
      apb(1'b0, idx, 8'h00);
      chk(nm, exp, rd, msk);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (IRQ !== 1'b1 && n < 3000) begin
         @(posedge MCLK);
         n++;
      end
      chk("irq", 8'h01, 8'(IRQ), 8'h01);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Whole run is under 5000 clocks; 40000 means a hang
   initial begin
      #1000000;
      n_mismatch++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge MCLK);
      RESETN <= 1'b1;
      for (int i = 0; i < 8; i++) rc("reset value", idx_t[i], rst_t[i], 8'hFF);
      rc("unmapped", 8'hD8, 8'h00, 8'hFF);
      chk("slverr", 8'h01, 8'(err), 8'h01);
      chk("pin level", 8'h00, {6'h00, lvl}, 8'h03);
      wr(`TWC_IDX_LOW, 8'h02);
      wr(`TWC_IDX_HIGH, 8'h02);
      wr(`TWC_IDX_HOLD, 8'h00);
      // A start request while disabled must be dropped, so enable goes first
      wr(`TWC_IDX_MODE, 8'h01);
      rc("disabled start", `TWC_IDX_MODE, 8'h00, 8'hFF);
      wr(`TWC_IDX_MODE, 8'h50);
      for (int a = 0; a < 2; a++) begin
         // Second pass addresses nobody, so the byte ends unacknowledged
         wr(`TWC_IDX_DATA, {7'h2A + 7'(a), 1'b0});
         wr(`TWC_IDX_MODE, 8'h51);
         wait_irq();
         rc("mode", `TWC_IDX_MODE, 8'hD4, 8'hFF);
         rc("status", `TWC_IDX_STATUS, a ? 8'h46 : 8'hC7, 8'hFF);
         chk("scl low", 8'h09, 8'(lo_len), 8'hFF);
         chk("scl high", 8'h0B, 8'(hi_len), 8'hFF);
         chk("scl held", 8'h01, 8'(SCL_PULL), 8'h01);
         wr(`TWC_IDX_MODE, 8'h52);
         wr(`TWC_IDX_STATUS, 8'h00);
         rc("status cleared", `TWC_IDX_STATUS, 8'h00, 8'h79);
         wait_irq();
         rc("stop seen", `TWC_IDX_STATUS, 8'h20, 8'h24);
         wr(`TWC_IDX_MODE, 8'hC0);
         @(posedge MCLK);
         chk("irq masked", 8'h00, 8'(IRQ), 8'h01);
         wr(`TWC_IDX_STATUS, 8'h00);
      end
      wr(`TWC_IDX_DATA, 8'h5A);
      wr(`TWC_IDX_MODE, 8'h60);
      rc("data after soft reset", `TWC_IDX_DATA, 8'hFF, 8'hFF);
      rc("soft reset bit", `TWC_IDX_MODE, 8'h00, 8'h20);
      stop_test();
   end
endmodule // tb_two_wire_bus_controller
